// ---- tsr_map.svh ----
// register addresses, field positions and prescale counts of the timer block
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH

// ************************************************************
// register addresses
// ************************************************************
`define TSR_ADDR_CONTROL       8'h88
`define TSR_ADDR_MODE          8'h89
`define TSR_ADDR_T0_LOW        8'h8a
`define TSR_ADDR_T1_LOW        8'h8b
`define TSR_ADDR_T0_HIGH       8'h8c
`define TSR_ADDR_T1_HIGH       8'h8d
`define TSR_ADDR_RATE          8'h8e
`define TSR_ADDR_T2_CONTROL    8'hc8
`define TSR_ADDR_T2_RCAP_LOW   8'hca
`define TSR_ADDR_T2_RCAP_HIGH  8'hcb
`define TSR_ADDR_T2_LOW        8'hcc
`define TSR_ADDR_T2_HIGH       8'hcd

// ************************************************************
// field positions
// ************************************************************
`define TSR_CTL_TF1            7
`define TSR_CTL_TR1            6
`define TSR_CTL_TF0            5
`define TSR_CTL_TR0            4
`define TSR_MODE_GATE1         7
`define TSR_MODE_CT1           6
`define TSR_MODE_GATE0         3
`define TSR_MODE_CT0           2
`define TSR_RATE_T2            5
`define TSR_RATE_T1            4
`define TSR_RATE_T0            3
`define TSR_T2_TF2             7
`define TSR_T2_TIMER2_EXTERNAL_FLAG            6
`define TSR_T2_RCLK            5
`define TSR_T2_TX_BAUD_FROM_TIMER2            4
`define TSR_T2_TIMER2_TRIGGER_ENABLE           3
`define TSR_T2_TR2             2
`define TSR_T2_CT2             1
`define TSR_T2_CPRL2           0

// ************************************************************
// reset values and prescale counts
// ************************************************************
`define TSR_RESET_BYTE         8'h00
`define TSR_DIV_SLOW           4'hc
`define TSR_DIV_FAST_MASK      2'h3

`endif

// ---- tsr_pkg.sv ----
// types shared by the timer block
`default_nettype none
package tsr_pkg;
  typedef logic [7:0] tsr_byte_t;
  // order follows the two-bit mode field encoding
  typedef enum logic [1:0] {
    TSR_MODE13,
    TSR_MODE16,
    TSR_MODE8_RELOAD,
    TSR_SPLIT
  } tsr_mode_e;
endpackage
`default_nettype wire

// ---- tsr_timer.sv ----
// timers 0/1 with split mode, per-timer rate select and the 16-bit timer 2
`timescale 1ns/1ps
`default_nettype none
`include "tsr_map.svh"

module tsr_timer (
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic [7:0]        SFR_ADDR,
  input  wire tsr_pkg::tsr_byte_t SFR_WDATA,
  input  wire logic              SFR_WE,
  input  wire logic              SFR_RE,
  output tsr_pkg::tsr_byte_t     SFR_RDATA,
  input  wire logic              TIMER0_COUNT_PIN,
  input  wire logic              TIMER1_COUNT_PIN,
  input  wire logic              TIMER2_COUNT_PIN,
  input  wire logic              TIMER2_TRIGGER_PIN,
  input  wire logic              EXTERNAL_INTERRUPT0_PIN,
  input  wire logic              EXTERNAL_INTERRUPT1_PIN,
  output logic                   TIMER0_OVERFLOW_FLAG,
  output logic                   TIMER1_OVERFLOW_FLAG,
  output logic                   TIMER2_REQUEST,
  output logic                   TIMER1_OVERFLOW_PULSE,
  output logic                   RX_BAUD_TICK,
  output logic                   TX_BAUD_TICK
);
  import tsr_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] target);
    sfr_hit = (a == target);
  endfunction

  // one timer step in modes 0-2: returns {overflow, high, low}
  function automatic logic [16:0] tmr_step(input tsr_mode_e m, input logic [7:0] tl,
                                           input logic [7:0] th);
    logic [13:0] c13;
    logic [16:0] c16;
    c13 = 14'({th, tl[4:0]}) + 14'h0001;
    c16 = 17'({th, tl}) + 17'h00001;
    tmr_step = {1'b0, th, tl};
    case (m)
      TSR_MODE13:       tmr_step = {c13[13], c13[12:5], tl[7:5], c13[4:0]};
      TSR_MODE16:       tmr_step = c16;
      TSR_MODE8_RELOAD: tmr_step = (tl == 8'hff) ? {1'b1, th, th} : {1'b0, th, tl + 8'h01};
      default:          tmr_step = {1'b0, th, tl};
    endcase
  endfunction

  // ************************************************************
  // prescaler and pin synchronisers
  // ************************************************************
  logic [3:0] pre_cnt;
  logic [3:0] next_pre_cnt;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_prev;
  logic [5:0] pin_fall;
  logic       tick_slow;
  logic       tick_fast;
  logic       tick_half;

  always_comb begin
    next_pre_cnt = (pre_cnt == `TSR_DIV_SLOW - 4'h1) ? 4'h0 : pre_cnt + 4'h1;
  end

  assign tick_slow = (pre_cnt == `TSR_DIV_SLOW - 4'h1);
  assign tick_fast = (pre_cnt[1:0] == `TSR_DIV_FAST_MASK);
  assign tick_half = pre_cnt[0];
  // order: int1, external_interrupt0_pin, trigger, t2, t1, t0
  assign pin_fall  = pin_prev & ~pin_s2;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pre_cnt  <= 4'h0;
      pin_s1   <= 6'h3f;
      pin_s2   <= 6'h3f;
      pin_prev <= 6'h3f;
    end else begin
      pre_cnt  <= next_pre_cnt;
      pin_s1   <= {EXTERNAL_INTERRUPT1_PIN, EXTERNAL_INTERRUPT0_PIN, TIMER2_TRIGGER_PIN,
                   TIMER2_COUNT_PIN, TIMER1_COUNT_PIN, TIMER0_COUNT_PIN};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  // ************************************************************
  // timers 0 and 1
  // ************************************************************
  tsr_byte_t tcon, timer_mode_register, timer_rate_select, tl0, th0, tl1, th1;
  tsr_byte_t next_tcon, next_timer_mode_register, next_timer_rate_select, next_tl0, next_th0, next_tl1, next_th1;
  tsr_mode_e mode0, mode1;
  logic      split, t0_tick, t1_tick, th0_tick;
  logic      t0_ovf, t1_ovf, th0_ovf;
  logic [16:0] step0, step1;

  assign mode0 = tsr_mode_e'(timer_mode_register[1:0]);
  assign mode1 = tsr_mode_e'(timer_mode_register[5:4]);
  assign split = (mode0 == TSR_SPLIT);
  assign t0_tick = tcon[`TSR_CTL_TR0] & (~timer_mode_register[`TSR_MODE_GATE0] | pin_s2[4])
                 & (timer_mode_register[`TSR_MODE_CT0] ? pin_fall[0]
                    : (timer_rate_select[`TSR_RATE_T0] ? tick_fast : tick_slow));
  // in split mode timer 1 loses its run bit to the high byte
  assign t1_tick = (split | tcon[`TSR_CTL_TR1]) & (mode1 != TSR_SPLIT)
                 & (~timer_mode_register[`TSR_MODE_GATE1] | pin_s2[5])
                 & (timer_mode_register[`TSR_MODE_CT1] ? pin_fall[1]
                    : (timer_rate_select[`TSR_RATE_T1] ? tick_fast : tick_slow));
  assign th0_tick = split & tcon[`TSR_CTL_TR1]
                  & (timer_rate_select[`TSR_RATE_T0] ? tick_fast : tick_slow);
  assign step0 = tmr_step(mode0, tl0, th0);
  assign step1 = tmr_step(mode1, tl1, th1);

  always_comb begin
    next_tl0 = tl0;
    next_th0 = th0;
    next_tl1 = tl1;
    next_th1 = th1;
    t0_ovf   = 1'b0;
    th0_ovf  = 1'b0;
    t1_ovf   = 1'b0;
    if (split) begin
      if (t0_tick) begin
        next_tl0 = tl0 + 8'h01;
        t0_ovf   = (tl0 == 8'hff);
      end
      if (th0_tick) begin
        next_th0 = th0 + 8'h01;
        th0_ovf  = (th0 == 8'hff);
      end
    end else if (t0_tick) begin
      {t0_ovf, next_th0, next_tl0} = step0;
    end
    if (t1_tick) begin
      {t1_ovf, next_th1, next_tl1} = step1;
    end
    // software writes win over counting on the written byte
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T0_LOW)) next_tl0 = SFR_WDATA;
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T0_HIGH)) next_th0 = SFR_WDATA;
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T1_LOW)) next_tl1 = SFR_WDATA;
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T1_HIGH)) next_th1 = SFR_WDATA;
    next_timer_mode_register  = (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_MODE)) ? SFR_WDATA : timer_mode_register;
    next_timer_rate_select = (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_RATE)) ? SFR_WDATA : timer_rate_select;
    next_tcon  = (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_CONTROL)) ? SFR_WDATA : tcon;
    // hardware set wins over a clear in the same cycle
    if (t0_ovf) next_tcon[`TSR_CTL_TF0] = 1'b1;
    if (split ? th0_ovf : t1_ovf) next_tcon[`TSR_CTL_TF1] = 1'b1;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tcon  <= `TSR_RESET_BYTE;
      timer_mode_register  <= `TSR_RESET_BYTE;
      timer_rate_select <= `TSR_RESET_BYTE;
      tl0   <= `TSR_RESET_BYTE;
      th0   <= `TSR_RESET_BYTE;
      tl1   <= `TSR_RESET_BYTE;
      th1   <= `TSR_RESET_BYTE;
    end else begin
      tcon  <= next_tcon;
      timer_mode_register  <= next_timer_mode_register;
      timer_rate_select <= next_timer_rate_select;
      tl0   <= next_tl0;
      th0   <= next_th0;
      tl1   <= next_tl1;
      th1   <= next_th1;
    end
  end

  // ************************************************************
  // timer 2
  // ************************************************************
  tsr_byte_t timer2_control, rcap_l, rcap_h, tl2, th2;
  tsr_byte_t next_timer2_control, next_rcap_l, next_rcap_h, next_tl2, next_th2;
  logic      baud, t2_tick, t2_ovf, t2_ext, t2_capture, t2_reload;

  assign baud = timer2_control[`TSR_T2_RCLK] | timer2_control[`TSR_T2_TX_BAUD_FROM_TIMER2];
  // the rate bit drops out in baud mode, where half the core clock is used
  assign t2_tick = timer2_control[`TSR_T2_TR2]
                 & (timer2_control[`TSR_T2_CT2] ? pin_fall[2]
                    : baud ? tick_half
                    : (timer_rate_select[`TSR_RATE_T2] ? tick_fast : tick_slow));
  assign t2_ovf = t2_tick & ({th2, tl2} == 16'hffff);
  assign t2_ext = timer2_control[`TSR_T2_TIMER2_TRIGGER_ENABLE] & pin_fall[3];
  assign t2_capture = t2_ext & ~baud & timer2_control[`TSR_T2_CPRL2];
  assign t2_reload = (baud | ~timer2_control[`TSR_T2_CPRL2])
                   & (t2_ovf | (t2_ext & ~baud));

  always_comb begin
    next_tl2    = tl2;
    next_th2    = th2;
    next_rcap_l = rcap_l;
    next_rcap_h = rcap_h;
    if (t2_reload) begin
      {next_th2, next_tl2} = {rcap_h, rcap_l};
    end else if (t2_tick) begin
      {next_th2, next_tl2} = {th2, tl2} + 16'h0001;
    end
    if (t2_capture) begin
      {next_rcap_h, next_rcap_l} = {th2, tl2};
    end
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T2_LOW)) next_tl2 = SFR_WDATA;
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T2_HIGH)) next_th2 = SFR_WDATA;
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T2_RCAP_LOW)) next_rcap_l = SFR_WDATA;
    if (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T2_RCAP_HIGH)) next_rcap_h = SFR_WDATA;
    next_timer2_control = (SFR_WE && sfr_hit(SFR_ADDR, `TSR_ADDR_T2_CONTROL)) ? SFR_WDATA : timer2_control;
    if (t2_ovf && !baud) next_timer2_control[`TSR_T2_TF2] = 1'b1;
    if (t2_ext) next_timer2_control[`TSR_T2_TIMER2_EXTERNAL_FLAG] = 1'b1;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      timer2_control  <= `TSR_RESET_BYTE;
      rcap_l <= `TSR_RESET_BYTE;
      rcap_h <= `TSR_RESET_BYTE;
      tl2    <= `TSR_RESET_BYTE;
      th2    <= `TSR_RESET_BYTE;
    end else begin
      timer2_control  <= next_timer2_control;
      rcap_l <= next_rcap_l;
      rcap_h <= next_rcap_h;
      tl2    <= next_tl2;
      th2    <= next_th2;
    end
  end

  // ************************************************************
  // read port and outputs
  // ************************************************************
  tsr_byte_t next_rdata;
  logic      next_t1_pulse, next_rx_tick, next_tx_tick;

  always_comb begin
    next_rdata = SFR_RDATA;
    if (SFR_RE) begin
      if (SFR_ADDR == `TSR_ADDR_CONTROL) next_rdata = tcon;
      else if (SFR_ADDR == `TSR_ADDR_MODE) next_rdata = timer_mode_register;
      else if (SFR_ADDR == `TSR_ADDR_T0_LOW) next_rdata = tl0;
      else if (SFR_ADDR == `TSR_ADDR_T1_LOW) next_rdata = tl1;
      else if (SFR_ADDR == `TSR_ADDR_T0_HIGH) next_rdata = th0;
      else if (SFR_ADDR == `TSR_ADDR_T1_HIGH) next_rdata = th1;
      else if (SFR_ADDR == `TSR_ADDR_RATE) next_rdata = timer_rate_select;
      else if (SFR_ADDR == `TSR_ADDR_T2_CONTROL) next_rdata = timer2_control;
      else if (SFR_ADDR == `TSR_ADDR_T2_RCAP_LOW) next_rdata = rcap_l;
      else if (SFR_ADDR == `TSR_ADDR_T2_RCAP_HIGH) next_rdata = rcap_h;
      else if (SFR_ADDR == `TSR_ADDR_T2_LOW) next_rdata = tl2;
      else if (SFR_ADDR == `TSR_ADDR_T2_HIGH) next_rdata = th2;
      else next_rdata = 8'h00;
    end
    next_t1_pulse = t1_ovf;
    next_rx_tick  = timer2_control[`TSR_T2_RCLK] ? t2_ovf : t1_ovf;
    next_tx_tick  = timer2_control[`TSR_T2_TX_BAUD_FROM_TIMER2] ? t2_ovf : t1_ovf;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SFR_RDATA             <= `TSR_RESET_BYTE;
      TIMER1_OVERFLOW_PULSE <= 1'b0;
      RX_BAUD_TICK          <= 1'b0;
      TX_BAUD_TICK          <= 1'b0;
    end else begin
      SFR_RDATA             <= next_rdata;
      TIMER1_OVERFLOW_PULSE <= next_t1_pulse;
      RX_BAUD_TICK          <= next_rx_tick;
      TX_BAUD_TICK          <= next_tx_tick;
    end
  end

  assign TIMER0_OVERFLOW_FLAG = tcon[`TSR_CTL_TF0];
  assign TIMER1_OVERFLOW_FLAG = tcon[`TSR_CTL_TF1];
  // a software-written one raises the request just as hardware does
  assign TIMER2_REQUEST = timer2_control[`TSR_T2_TF2] | timer2_control[`TSR_T2_TIMER2_EXTERNAL_FLAG];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  split_low_ovf_a: assert property (split && t0_tick && tl0 == 8'hff && !SFR_WE
    |=> tcon[`TSR_CTL_TF0] && tl0 == 8'h00)
    else $error("split low byte overflow lost");
  split_high_flag_a: assert property (split && th0_tick && th0 == 8'hff && !SFR_WE
    |=> tcon[`TSR_CTL_TF1] && th0 == 8'h00)
    else $error("split high byte flag lost");
  split_gate_a: assert property (split && timer_mode_register[`TSR_MODE_GATE0] && !pin_s2[4]
    && !SFR_WE |=> $stable(tl0))
    else $error("gated low byte moved");
  th0_run_a: assert property (split && !tcon[`TSR_CTL_TR1] && !SFR_WE
    |=> $stable(th0))
    else $error("high byte moved without timer 1 run");
  t1_halt_a: assert property (mode1 == TSR_SPLIT && !SFR_WE
    |=> $stable({th1, tl1}))
    else $error("timer 1 moved in mode 3");
  t1_pulse_a: assert property (t1_ovf
    |=> TIMER1_OVERFLOW_PULSE)
    else $error("timer 1 overflow pulse missing");
  t2_hold_a: assert property (!timer2_control[`TSR_T2_TR2] && !t2_ext && !SFR_WE
    |=> $stable({th2, tl2}))
    else $error("timer 2 moved while stopped");
  t2_baud_flag_a: assert property (baud && !timer2_control[`TSR_T2_TF2] && !SFR_WE
    |=> !timer2_control[`TSR_T2_TF2])
    else $error("overflow flag set in baud mode");
  t2_ovf_flag_a: assert property (t2_ovf && !baud
    |=> timer2_control[`TSR_T2_TF2])
    else $error("timer 2 overflow flag not set");
  t2_flag_hold_a: assert property (timer2_control[`TSR_T2_TF2] && !SFR_WE
    |=> timer2_control[`TSR_T2_TF2])
    else $error("timer 2 overflow flag dropped");
  t2_reload_a: assert property (t2_ovf && (baud || !timer2_control[`TSR_T2_CPRL2]) && !SFR_WE
    |=> {th2, tl2} == $past({rcap_h, rcap_l}))
    else $error("timer 2 reload missed");
  t2_capture_a: assert property (t2_capture && !SFR_WE
    |=> {rcap_h, rcap_l} == $past({th2, tl2}))
    else $error("capture missed");
  baud_no_capture_a: assert property (baud && !SFR_WE
    |=> $stable({rcap_h, rcap_l}))
    else $error("reload registers changed in baud mode");
  trig_ignore_a: assert property (!timer2_control[`TSR_T2_TIMER2_TRIGGER_ENABLE] && !timer2_control[`TSR_T2_TIMER2_EXTERNAL_FLAG]
    && !SFR_WE |=> !timer2_control[`TSR_T2_TIMER2_EXTERNAL_FLAG])
    else $error("external flag set while disabled");
  ext_flag_hold_a: assert property (timer2_control[`TSR_T2_TIMER2_EXTERNAL_FLAG] && !SFR_WE
    |=> timer2_control[`TSR_T2_TIMER2_EXTERNAL_FLAG])
    else $error("external flag dropped");
  baud_select_a: assert property (##1 RX_BAUD_TICK ==
    $past(timer2_control[`TSR_T2_RCLK] ? t2_ovf : t1_ovf))
    else $error("receive tick source wrong");

  // ************************************************************
  // prescaler and pin checks
  // ************************************************************
  // eleven idle cycles between slow ticks, three between fast ones
  slow_rate_a: assert property (tick_slow
    |=> !tick_slow [*8] ##1 !tick_slow ##1 !tick_slow ##1 !tick_slow ##1 tick_slow)
    else $error("slow prescale not twelve");
  fast_rate_a: assert property (tick_fast
    |=> !tick_fast ##1 !tick_fast ##1 !tick_fast ##1 tick_fast)
    else $error("fast prescale not four");
  half_rate_a: assert property (tick_half
    |=> !tick_half ##1 tick_half)
    else $error("baud prescale not two");
  count_pin_a: assert property (timer2_control[`TSR_T2_TR2] && timer2_control[`TSR_T2_CT2]
    && !pin_fall[2] && !t2_ext && !SFR_WE |=> $stable({th2, tl2}))
    else $error("timer 2 counted without a pin fall");

  split_ovf_c: cover property (split && t0_ovf);
  t1_split_ovf_c: cover property (split && t1_ovf);
  t2_capture_c: cover property (t2_capture);
  t2_baud_c: cover property (baud && t2_ovf);
  t2_ext_reload_c: cover property (t2_reload && t2_ext);
endmodule // tsr_timer
`default_nettype wire

// ---- timer_split_rate_and_timer2_test.sv ----
// self-checking testbench of the split-mode, rate-select and timer 2 block
`timescale 1ns/1ps
`default_nettype none
`include "tsr_map.svh"

module timer_split_rate_and_timer2_test;
  import tsr_pkg::*;
  logic       clk;
  logic       reset;
  logic [7:0] addr;
  tsr_byte_t  wdata;
  logic       we;
  logic       re;
  tsr_byte_t  rdata;
  logic [3:0] pins;  // trigger, timer2, timer1, timer0 count pins
  logic       external_interrupt0_pin;
  logic       int1;
  logic [2:0] fl;    // request, timer1 flag, timer0 flag
  logic [15:0] v;
  logic       tf0, tf1, t2_req, rx_tick, tx_tick, t1_pulse;
  int         n_fail, n_compared, n_tx, n_rx, n_pulse;

  tsr_timer u_dut (.CLK(clk), .RESET(reset), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdata), .TIMER0_COUNT_PIN(pins[0]),
    .TIMER1_COUNT_PIN(pins[1]), .TIMER2_COUNT_PIN(pins[2]), .TIMER2_TRIGGER_PIN(pins[3]),
    .EXTERNAL_INTERRUPT0_PIN(external_interrupt0_pin), .EXTERNAL_INTERRUPT1_PIN(int1),
    .TIMER0_OVERFLOW_FLAG(tf0), .TIMER1_OVERFLOW_FLAG(tf1), .TIMER2_REQUEST(t2_req),
    .TIMER1_OVERFLOW_PULSE(t1_pulse), .RX_BAUD_TICK(rx_tick), .TX_BAUD_TICK(tx_tick));

  // ************************************************************
  // clock, tick counters, bus tasks
  // ************************************************************
  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (tx_tick === 1'b1) n_tx++;
    if (rx_tick === 1'b1) n_rx++;
    if (t1_pulse === 1'b1) n_pulse++;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    we = 1'b1;
    @(posedge clk);
    #1;
    we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    re = 1'b1;
    @(posedge clk);
    #1;
    re = 1'b0;
    d = rdata;
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask

  // exactly 48 counting edges between the start and the stop write
  task automatic window(input logic [7:0] a, input logic [7:0] run, input logic [7:0] stop);
    wr(a, run);
    repeat (46) @(posedge clk);
    #1;
    fl = {t2_req, tf1, tf0};
    wr(a, stop);
  endtask

  // the fall shows three edges late, so the pin is held well past it
  task automatic fall(input int i);
    @(posedge clk);
    #1;
    pins[i] = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    pins[i] = 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset;
    logic [7:0] al [7] = '{8'h8e, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
    foreach (al[i]) begin
      rd(al[i], v[7:0]);
      check(v[7:0], 8'h00);
    end
    wr(`TSR_ADDR_RATE, 8'h38);
    rd(`TSR_ADDR_RATE, v[7:0]);
    check(v[7:0], 8'h38);
    $display("test_reset done");
  endtask

  task automatic test_rate;
    logic [7:0] rt [3] = '{8'h20, 8'h00, 8'h18};
    logic [15:0] ex [3] = '{16'd12, 16'd4, 16'd4};
    foreach (rt[i]) begin
      wr(`TSR_ADDR_RATE, rt[i]);
      wr16(`TSR_ADDR_T2_LOW, 16'h0000);
      window(`TSR_ADDR_T2_CONTROL, 8'h04, 8'h00);
      rd16(`TSR_ADDR_T2_LOW, v);
      check(v, ex[i]);
    end
    repeat (24) @(posedge clk);
    rd16(`TSR_ADDR_T2_LOW, v);
    check(v, 16'd4);
    $display("test_rate done");
  endtask

  task automatic test_overflow;
    wr16(`TSR_ADDR_T2_RCAP_LOW, 16'h1234);
    wr(`TSR_ADDR_RATE, 8'h20);
    wr16(`TSR_ADDR_T2_LOW, 16'hffff);
    window(`TSR_ADDR_T2_CONTROL, 8'h04, 8'h00);
    check(fl[2], 1'b1);
    check(t2_req, 1'b0);
    rd16(`TSR_ADDR_T2_LOW, v);
    check(v, 16'h123f);
    // baud mode: half-rate ticks, rate bit and capture select ignored
    wr16(`TSR_ADDR_T2_LOW, 16'hffff);
    n_tx = 0;
    n_rx = 0;
    window(`TSR_ADDR_T2_CONTROL, 8'h15, 8'h11);
    check(fl[2], 1'b0);
    rd16(`TSR_ADDR_T2_LOW, v);
    check(v, 16'h124b);
    check(n_tx[1:0], 2'd1);
    check(n_rx[1:0], 2'd0);
    wr(`TSR_ADDR_T2_CONTROL, 8'h00);
    $display("test_overflow done");
  endtask

  task automatic test_count_pin;
    wr16(`TSR_ADDR_T2_LOW, 16'h0000);
    wr(`TSR_ADDR_T2_CONTROL, 8'h06);
    repeat (3) fall(2);
    wr(`TSR_ADDR_T2_CONTROL, 8'h00);
    rd16(`TSR_ADDR_T2_LOW, v);
    check(v, 16'd3);
    $display("test_count_pin done");
  endtask

  task automatic test_trigger;
    wr16(`TSR_ADDR_T2_LOW, 16'h5678);
    wr(`TSR_ADDR_T2_CONTROL, 8'h09);
    fall(3);
    rd16(`TSR_ADDR_T2_RCAP_LOW, v);
    check(v, 16'h5678);
    rd(`TSR_ADDR_T2_CONTROL, v[7:0]);
    check(v[7:0], 8'h49);
    check(t2_req, 1'b1);
    wr(`TSR_ADDR_T2_CONTROL, 8'h01);
    wr16(`TSR_ADDR_T2_LOW, 16'h1111);
    fall(3);
    rd16(`TSR_ADDR_T2_RCAP_LOW, v);
    check(v, 16'h5678);
    check(t2_req, 1'b0);
    wr(`TSR_ADDR_T2_CONTROL, 8'h08);
    fall(3);
    rd16(`TSR_ADDR_T2_LOW, v);
    check(v, 16'h5678);
    wr(`TSR_ADDR_T2_CONTROL, 8'h80);
    check(t2_req, 1'b1);
    wr(`TSR_ADDR_T2_CONTROL, 8'h00);
    check(t2_req, 1'b0);
    $display("test_trigger done");
  endtask

  task automatic test_split;
    wr(`TSR_ADDR_RATE, 8'h10);
    wr(`TSR_ADDR_T1_LOW, 8'h00);
    window(`TSR_ADDR_MODE, 8'h13, 8'h33);
    rd(`TSR_ADDR_T1_LOW, v[7:0]);
    check(v[7:0], 8'h0c);
    repeat (24) @(posedge clk);
    rd(`TSR_ADDR_T1_LOW, v[7:0]);
    check(v[7:0], 8'h0c);
    wr(`TSR_ADDR_RATE, 8'h08);
    wr(`TSR_ADDR_MODE, 8'h3b);
    for (int g = 1; g >= 0; g--) begin
      external_interrupt0_pin = g[0];
      wr(`TSR_ADDR_T0_LOW, 8'hfe);
      wr(`TSR_ADDR_T0_HIGH, 8'hfb);
      window(`TSR_ADDR_CONTROL, 8'h50, 8'h00);
      check(fl[1:0], {1'b1, g[0]});
      rd(`TSR_ADDR_T0_LOW, v[7:0]);
      check(v[7:0], g[0] ? 8'h0a : 8'hfe);
      rd(`TSR_ADDR_T0_HIGH, v[7:0]);
      check(v[7:0], 8'h07);
    end
    external_interrupt0_pin = 1'b1;
    $display("test_split done");
  endtask

  // split: timer 1 as gated 8-bit reload baud source; then timer 0 in 13-bit mode
  task automatic test_t1_baud;
    wr(`TSR_ADDR_RATE, 8'h10);
    for (int g = 1; g >= 0; g--) begin
      int1 = g[0];
      wr(`TSR_ADDR_T1_LOW, 8'hfe);
      wr(`TSR_ADDR_T1_HIGH, 8'hfe);
      n_tx = 0;
      n_rx = 0;
      n_pulse = 0;
      window(`TSR_ADDR_MODE, 8'ha3, 8'h33);
      repeat (2) @(posedge clk);
      check(n_pulse[15:0], g[0] ? 16'd6 : 16'd0);
      check(n_rx[15:0], g[0] ? 16'd6 : 16'd0);
      check(n_tx[15:0], g[0] ? 16'd6 : 16'd0);
      check(fl[1], 1'b0);
      rd(`TSR_ADDR_T1_LOW, v[7:0]);
      check(v[7:0], 8'hfe);
    end
    int1 = 1'b1;
    wr(`TSR_ADDR_RATE, 8'h08);
    wr(`TSR_ADDR_MODE, 8'h30);
    wr(`TSR_ADDR_T0_LOW, 8'h1e);
    wr(`TSR_ADDR_T0_HIGH, 8'hff);
    window(`TSR_ADDR_CONTROL, 8'h10, 8'h00);
    check(fl[0], 1'b1);
    rd(`TSR_ADDR_T0_LOW, v[7:0]);
    check(v[7:0], 8'h0a);
    rd(`TSR_ADDR_T0_HIGH, v[7:0]);
    check(v[7:0], 8'h00);
    $display("test_t1_baud done");
  endtask

  // ************************************************************
  // main sequence and hang guard
  // ************************************************************
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
    pins = 4'hf;
    external_interrupt0_pin = 1'b1;
    int1 = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    test_reset();
    test_rate();
    test_overflow();
    test_count_pin();
    test_trigger();
    test_split();
    test_t1_baud();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("Error at %0t: run did not finish in time", $time);
    give_verdict();
  end
endmodule // timer_split_rate_and_timer2_test
`default_nettype wire
